/* rec_pkg.sv */
// Shared constants and record types for the event and start recorders.
package rec_pkg;
  // ==========================================================================
  // Sizes and timing
  // ==========================================================================
  localparam logic [8:0] LOG_DEPTH    = 9'h12c;
  localparam logic [8:0] RETAIN_DEPTH = 9'h032;
  localparam logic [2:0] START_DEPTH  = 3'h5;
  localparam logic [2:0] TRACE_LAST   = 3'h7;
  localparam int         CLK_MHZ      = 100;
  localparam int         SAMPLE_MS    = 50;
  localparam int         SAMPLE_CYCLES = SAMPLE_MS * 1000 * CLK_MHZ;

  // ==========================================================================
  // Event kinds
  // ==========================================================================
  localparam logic [1:0] KIND_BINARY  = 2'h0;
  localparam logic [1:0] KIND_COUNTER = 2'h1;
  localparam logic [1:0] KIND_MULTI   = 2'h2;

  // ==========================================================================
  // Record types
  // ==========================================================================
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] itemId;
    logic [7:0] prevVal;
    logic [7:0] curVal;
  } event_in_t;

  typedef struct packed {
    logic [15:0] seqNo;
    logic [15:0] faultNo;
    logic [15:0] gridNo;
    logic [31:0] stamp;
    logic [7:0]  itemId;
    logic [7:0]  oldVal;
    logic [7:0]  newVal;
  } log_entry_t;

  typedef struct packed {
    logic [15:0] i1;
    logic [15:0] i2;
    logic [15:0] i3;
    logic [15:0] unbal;
    logic [15:0] thermal;
    logic [15:0] temp;
  } analog_t;

  typedef struct packed {
    logic [31:0] stamp;
    logic [15:0] recNo;
    logic [15:0] maxI1;
    logic [15:0] maxI2;
    logic [15:0] maxI3;
    logic [15:0] maxUnbal;
    logic        twoSpeed;
    logic [15:0] thermal;
    logic [15:0] transitTime;
    logic [15:0] runTime;
    logic        incomplete;
    logic        success;
  } start_sum_t;

  // Slot of the entry that is age places older than the newest one.
  function automatic logic [9:0] ringSlot(logic [9:0] wr, logic [9:0] age,
                                          logic [9:0] depth);
    logic [10:0] s;
    s = {1'b0, wr} + {1'b0, depth} - 11'h001 - {1'b0, age};
    if (s >= {1'b0, depth}) begin
      s = s - {1'b0, depth};
    end
    return s[9:0];
  endfunction
endpackage

/* start_recorder.sv */
// Motor start recorder with summary data and sampled analogue traces.
`timescale 1ns/1ps
module start_recorder #(
  parameter int SAMPLE_CYCLES = rec_pkg::SAMPLE_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               motorStartTrigger,
  input  wire logic               motorRun,
  input  wire logic               speed2,
  input  wire logic               currentBelowTransit,
  input  wire logic               remoteTempPresent,
  input  wire rec_pkg::analog_t   chan,
  input  wire logic [31:0]        timeStamp,
  input  wire logic [2:0]         rdIdx,
  input  wire logic [2:0]         rdSample,
  output logic                    storing,
  output logic [2:0]              startCount,
  output rec_pkg::start_sum_t     rdSum,
  output rec_pkg::analog_t        rdTrace
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_CAPTURE = 3'b010, ST_STORE = 3'b100
  } st_t;

  st_t                 state_ff, nxt_state;
  rec_pkg::start_sum_t work_ff, nxt_work;
  logic [22:0]         tickCnt_ff, nxt_tickCnt;
  logic [2:0]          sample_ff, nxt_sample;
  logic [2:0]          wrPtr_ff, nxt_wrPtr;
  logic [2:0]          count_ff, nxt_count;
  logic                startPrev_ff, transitSeen_ff, nxt_transitSeen;
  logic                tick, traceWe, sumWe;
  logic [2:0]          rdSlot;
  rec_pkg::analog_t    sampleVal;
  rec_pkg::start_sum_t sumMem [int'(rec_pkg::START_DEPTH)];
  rec_pkg::analog_t    traceMem [int'(rec_pkg::START_DEPTH)][8];

  // ==========================================================================
  // Capture sequence
  // ==========================================================================
  always_comb begin
    nxt_state       = state_ff;
    nxt_work        = work_ff;
    nxt_tickCnt     = tickCnt_ff;
    nxt_sample      = sample_ff;
    nxt_wrPtr       = wrPtr_ff;
    nxt_count       = count_ff;
    nxt_transitSeen = transitSeen_ff;
    traceWe         = 1'b0;
    sumWe           = 1'b0;
    tick            = tickCnt_ff == 23'(SAMPLE_CYCLES - 1);
    sampleVal       = chan;
    if (!remoteTempPresent) begin
      sampleVal.temp = 16'h0000;
    end
    unique case (state_ff)
      ST_IDLE: begin
        if (motorStartTrigger && !startPrev_ff) begin
          nxt_state             = ST_CAPTURE;
          nxt_work              = '0;
          nxt_work.stamp        = timeStamp;
          nxt_work.recNo        = work_ff.recNo + 16'h0001;
          nxt_work.twoSpeed     = speed2;
          nxt_tickCnt           = 23'h000000;
          nxt_sample            = 3'h0;
          nxt_transitSeen       = 1'b0;
          traceWe               = 1'b1;
        end
      end
      ST_CAPTURE: begin
        nxt_tickCnt = tick ? 23'h000000 : tickCnt_ff + 23'h000001;
        if (chan.i1 > work_ff.maxI1) nxt_work.maxI1 = chan.i1;
        if (chan.i2 > work_ff.maxI2) nxt_work.maxI2 = chan.i2;
        if (chan.i3 > work_ff.maxI3) nxt_work.maxI3 = chan.i3;
        if (chan.unbal > work_ff.maxUnbal) nxt_work.maxUnbal = chan.unbal;
        nxt_work.thermal = chan.thermal;
        if (tick) begin
          nxt_work.runTime = work_ff.runTime + 16'h0001;
          if (!transitSeen_ff) begin
            nxt_work.transitTime = work_ff.transitTime + 16'h0001;
          end
          if (sample_ff != rec_pkg::TRACE_LAST) begin
            nxt_sample = sample_ff + 3'h1;
            traceWe    = 1'b1;
          end
        end
        if (currentBelowTransit) nxt_transitSeen = 1'b1;
        if (motorRun) begin
          nxt_work.success = 1'b1;
          nxt_state        = ST_STORE;
        end else if (!motorStartTrigger) begin
          nxt_work.incomplete = 1'b1;
          nxt_state           = ST_STORE;
        end
      end
      ST_STORE: begin
        sumWe     = 1'b1;
        nxt_state = ST_IDLE;
        nxt_wrPtr = (wrPtr_ff == rec_pkg::START_DEPTH - 3'h1) ? 3'h0
                  : wrPtr_ff + 3'h1;
        if (count_ff != rec_pkg::START_DEPTH) nxt_count = count_ff + 3'h1;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff       <= ST_IDLE;
      work_ff        <= '0;
      tickCnt_ff     <= 23'h000000;
      sample_ff      <= 3'h0;
      wrPtr_ff       <= 3'h0;
      count_ff       <= 3'h0;
      startPrev_ff   <= 1'b0;
      transitSeen_ff <= 1'b0;
      rdSum          <= '0;
      rdTrace        <= '0;
    end else begin
      state_ff       <= nxt_state;
      work_ff        <= nxt_work;
      tickCnt_ff     <= nxt_tickCnt;
      sample_ff      <= nxt_sample;
      wrPtr_ff       <= nxt_wrPtr;
      count_ff       <= nxt_count;
      startPrev_ff   <= motorStartTrigger;
      transitSeen_ff <= nxt_transitSeen;
      rdSum          <= sumMem[rdSlot];
      rdTrace        <= traceMem[rdSlot][rdSample];
    end
  end

  // ==========================================================================
  // Record storage
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (sumWe) sumMem[wrPtr_ff] <= work_ff;
    if (traceWe) traceMem[wrPtr_ff][nxt_sample] <= sampleVal;
  end

  assign rdSlot     = 3'(rec_pkg::ringSlot(10'(wrPtr_ff), 10'(rdIdx),
                                           10'(rec_pkg::START_DEPTH)));
  assign storing    = state_ff != ST_IDLE;
  assign startCount = count_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_startBegins;
    @(posedge clk) disable iff (!resetn)
      (state_ff == ST_IDLE && motorStartTrigger && !startPrev_ff)
        |=> storing && state_ff == ST_CAPTURE;
  endproperty
  a_startBegins: assert property (p_startBegins)
    else $error("Start edge did not begin a recording.");

  property p_fifoFull;
    @(posedge clk) disable iff (!resetn)
      (state_ff == ST_STORE && count_ff == rec_pkg::START_DEPTH)
        |=> count_ff == rec_pkg::START_DEPTH && wrPtr_ff != $past(wrPtr_ff);
  endproperty
  a_fifoFull: assert property (p_fifoFull)
    else $error("Full start store did not overwrite the oldest record.");

  property p_storingHeld;
    @(posedge clk) disable iff (!resetn)
      (state_ff == ST_CAPTURE && motorRun) |=> storing ##1 !storing;
  endproperty
  a_storingHeld: assert property (p_storingHeld)
    else $error("Storing output wrong around the store cycle.");
endmodule // start_recorder

/* event_and_start_recorder.sv */
// Event log with fault counters, plus the motor start recorder instance.
`timescale 1ns/1ps
module event_and_start_recorder #(
  parameter int SAMPLE_CYCLES = rec_pkg::SAMPLE_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                evtValid,
  input  wire rec_pkg::event_in_t  evtIn,
  input  wire logic                protAlarm,
  input  wire logic                autoReclosing,
  input  wire logic                reclosingActive,
  input  wire logic [31:0]         timeStamp,
  input  wire logic                clearAll,
  input  wire logic [8:0]          rdIdx,
  output rec_pkg::log_entry_t      rdEntry,
  output logic                     rdValid,
  output logic [8:0]               entryCount,
  output logic [8:0]               retainedCount,
  output logic                     allDeleted,
  input  wire logic                motorStartTrigger,
  input  wire logic                motorRun,
  input  wire logic                speed2,
  input  wire logic                currentBelowTransit,
  input  wire logic                remoteTemperatureUnit,
  input  wire rec_pkg::analog_t    chan,
  input  wire logic [2:0]          startRdIdx,
  input  wire logic [2:0]          startRdSample,
  output logic                     storing,
  output logic [2:0]               startCount,
  output rec_pkg::start_sum_t      startRdSum,
  output rec_pkg::analog_t         startRdTrace
);
  logic [15:0]         seqNo_ff, nxt_seqNo;
  logic [15:0]         faultNo_ff, nxt_faultNo;
  logic [15:0]         gridNo_ff, nxt_gridNo;
  logic [8:0]          wrPtr_ff, nxt_wrPtr;
  logic [8:0]          count_ff, nxt_count;
  logic                alarmPrev_ff, clearPrev_ff, allDeleted_ff;
  logic                alarmRise, clrRise;
  rec_pkg::log_entry_t newEntry, lastWritten_ff;
  logic [8:0]          rdSlot;
  rec_pkg::log_entry_t logMem [int'(rec_pkg::LOG_DEPTH)];

  // ==========================================================================
  // Counters and entry build
  // ==========================================================================
  always_comb begin
    alarmRise   = protAlarm && !alarmPrev_ff;
    clrRise     = clearAll && !clearPrev_ff;
    nxt_faultNo = alarmRise ? faultNo_ff + 16'h0001 : faultNo_ff;
    nxt_gridNo  = gridNo_ff;
    if (alarmRise && !(autoReclosing && reclosingActive)) begin
      nxt_gridNo = gridNo_ff + 16'h0001;
    end
    nxt_wrPtr = clrRise ? 9'h000 : wrPtr_ff;
    nxt_count = clrRise ? 9'h000 : count_ff;
    nxt_seqNo = seqNo_ff;
    newEntry         = '0;
    newEntry.seqNo   = seqNo_ff + 16'h0001;
    newEntry.faultNo = nxt_faultNo;
    newEntry.gridNo  = nxt_gridNo;
    newEntry.stamp   = timeStamp;
    newEntry.itemId  = evtIn.itemId;
    unique case (evtIn.kind)
      rec_pkg::KIND_BINARY: begin
        newEntry.oldVal = {7'h00, !evtIn.curVal[0]};
        newEntry.newVal = {7'h00, evtIn.curVal[0]};
      end
      rec_pkg::KIND_COUNTER: begin
        newEntry.oldVal = evtIn.curVal - 8'h01;
        newEntry.newVal = evtIn.curVal;
      end
      default: begin
        newEntry.oldVal = evtIn.prevVal;
        newEntry.newVal = evtIn.curVal;
      end
    endcase
    if (evtValid) begin
      nxt_seqNo = newEntry.seqNo;
      nxt_wrPtr = (nxt_wrPtr == rec_pkg::LOG_DEPTH - 9'h001) ? 9'h000
                : nxt_wrPtr + 9'h001;
      if (nxt_count != rec_pkg::LOG_DEPTH) begin
        nxt_count = nxt_count + 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seqNo_ff       <= 16'h0000;
      faultNo_ff     <= 16'h0000;
      gridNo_ff      <= 16'h0000;
      wrPtr_ff       <= 9'h000;
      count_ff       <= 9'h000;
      alarmPrev_ff   <= 1'b0;
      clearPrev_ff   <= 1'b0;
      allDeleted_ff  <= 1'b0;
      lastWritten_ff <= '0;
      rdEntry        <= '0;
    end else begin
      seqNo_ff       <= nxt_seqNo;
      faultNo_ff     <= nxt_faultNo;
      gridNo_ff      <= nxt_gridNo;
      wrPtr_ff       <= nxt_wrPtr;
      count_ff       <= nxt_count;
      alarmPrev_ff   <= protAlarm;
      clearPrev_ff   <= clearAll;
      allDeleted_ff  <= clrRise;
      if (evtValid) lastWritten_ff <= newEntry;
      rdEntry        <= logMem[rdSlot];
    end
  end

  // ==========================================================================
  // Log storage, left unreset; reset still zeroes count_ff and wrPtr_ff, so entryCount drops to 0
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (evtValid) begin
      logMem[clrRise ? 9'h000 : wrPtr_ff] <= newEntry;
    end
  end

  assign rdSlot = 9'(rec_pkg::ringSlot(10'(wrPtr_ff), 10'(rdIdx),
                                       10'(rec_pkg::LOG_DEPTH)));
  assign rdValid       = rdIdx < count_ff;
  assign entryCount    = count_ff;
  assign retainedCount = (count_ff > rec_pkg::RETAIN_DEPTH) ?
                         rec_pkg::RETAIN_DEPTH : count_ff;
  assign allDeleted    = allDeleted_ff;

  // ==========================================================================
  // Motor start recorder
  // ==========================================================================
  start_recorder #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) startRec (
    .clk                 (clk),
    .resetn              (resetn),
    .motorStartTrigger   (motorStartTrigger),
    .motorRun            (motorRun),
    .speed2              (speed2),
    .currentBelowTransit (currentBelowTransit),
    .remoteTempPresent   (remoteTemperatureUnit),
    .chan                (chan),
    .timeStamp           (timeStamp),
    .rdIdx               (startRdIdx),
    .rdSample            (startRdSample),
    .storing             (storing),
    .startCount          (startCount),
    .rdSum               (startRdSum),
    .rdTrace             (startRdTrace)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_capacity;
    @(posedge clk) disable iff (!resetn)
      (count_ff == rec_pkg::LOG_DEPTH && evtValid && !clrRise)
        |=> count_ff == rec_pkg::LOG_DEPTH;
  endproperty
  a_capacity: assert property (p_capacity)
    else $error("Full log count changed on a new event.");

  property p_seq;
    @(posedge clk) disable iff (!resetn)
      evtValid |=> seqNo_ff == $past(seqNo_ff) + 16'h0001
                   && lastWritten_ff.seqNo == seqNo_ff;
  endproperty
  a_seq: assert property (p_seq)
    else $error("Sequence number did not advance by one.");

  property p_fault;
    @(posedge clk) disable iff (!resetn)
      (protAlarm && !alarmPrev_ff)
        |=> faultNo_ff == $past(faultNo_ff) + 16'h0001;
  endproperty
  a_fault: assert property (p_fault)
    else $error("Fault number did not advance on alarm.");

  property p_grid;
    @(posedge clk) disable iff (!resetn)
      (protAlarm && !alarmPrev_ff && !autoReclosing)
        |=> gridNo_ff == $past(gridNo_ff) + 16'h0001;
  endproperty
  a_grid: assert property (p_grid)
    else $error("Grid fault number did not advance on alarm.");

  property p_binary;
    @(posedge clk) disable iff (!resetn)
      (evtValid && evtIn.kind == rec_pkg::KIND_BINARY && evtIn.curVal[0])
        |=> lastWritten_ff.oldVal == 8'h00 && lastWritten_ff.newVal == 8'h01;
  endproperty
  a_binary: assert property (p_binary)
    else $error("Rising binary change not logged as 0 to 1.");

  property p_counter;
    @(posedge clk) disable iff (!resetn)
      (evtValid && evtIn.kind == rec_pkg::KIND_COUNTER)
        |=> lastWritten_ff.newVal == lastWritten_ff.oldVal + 8'h01;
  endproperty
  a_counter: assert property (p_counter)
    else $error("Counter change not logged as old then new.");

  property p_multi;
    @(posedge clk) disable iff (!resetn)
      (evtValid && evtIn.kind == rec_pkg::KIND_MULTI)
        |=> lastWritten_ff.oldVal == $past(evtIn.prevVal);
  endproperty
  a_multi: assert property (p_multi)
    else $error("Multi-state change lost its old state.");

  property p_clear;
    @(posedge clk) disable iff (!resetn)
      (clearAll && !clearPrev_ff && !evtValid)
        |=> count_ff == 9'h000 && allDeleted ##1 !allDeleted;
  endproperty
  a_clear: assert property (p_clear)
    else $error("Clear command did not erase the log.");
endmodule // event_and_start_recorder

/* log_operator.sv */
// Operator model that reads log entries and clears the event log.
`timescale 1ns/1ps
module log_operator (
  input  wire logic                clk,
  input  wire rec_pkg::log_entry_t rdEntry,
  input  wire logic                allDeleted,
  output logic                     clearAll,
  output logic [8:0]               rdIdx
);
  // ==========================================================================
  // Requests
  // ==========================================================================
  initial begin
    clearAll = 1'b0;
    rdIdx    = 9'h000;
  end

  // Selects an entry by age and takes the registered answer.
  task automatic readEntry(input logic [8:0] age,
                           output rec_pkg::log_entry_t e);
    @(posedge clk);
    rdIdx <= age;
    @(posedge clk);
    #1;
    e = rdEntry;
  endtask

  // Drives the clear command from inactive to active and back.
  task automatic clearLog(output logic del);
    @(posedge clk);
    clearAll <= 1'b1;
    @(posedge clk);
    clearAll <= 1'b0;
    #1;
    del = allDeleted;
  endtask
endmodule // log_operator

/* test_event_and_start_recorder.sv */
// Self-checking testbench for the event and motor start recorder.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin total_checks++; if ((e) !== (a)) begin \
  num_errors++; $display("BAD %s exp %0h got %0h", nm, e, a); end end
module test_event_and_start_recorder;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk = 1'b0;
  logic resetn, evtValid, protAlarm, autoReclosing, reclosingActive;
  logic motorStartTrigger, motorRun, speed2, currentBelowTransit;
  logic remoteTemperatureUnit, clearAll, rdValid, allDeleted, storing;
  logic [31:0] timeStamp;
  logic [8:0] rdIdx, entryCount, retainedCount;
  logic [2:0] startRdIdx, startRdSample, startCount;
  rec_pkg::event_in_t evtIn;
  rec_pkg::log_entry_t rdEntry;
  rec_pkg::analog_t chan, startRdTrace;
  rec_pkg::start_sum_t startRdSum;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 32'he647;
  logic [15:0] seq = 16'h0000, fault = 16'h0000, grid = 16'h0000;
  logic [15:0] recNo = 16'h0000;
  logic prevAl = 1'b0;
  int nStarts = 0;

  always #5 clk = ~clk;

  localparam int SAMPLE_TICK = 4;
  event_and_start_recorder #(.SAMPLE_CYCLES(SAMPLE_TICK)) u_dut (
    .clk(clk), .resetn(resetn), .evtValid(evtValid), .evtIn(evtIn),
    .protAlarm(protAlarm), .autoReclosing(autoReclosing),
    .reclosingActive(reclosingActive), .timeStamp(timeStamp),
    .clearAll(clearAll), .rdIdx(rdIdx), .rdEntry(rdEntry),
    .rdValid(rdValid), .entryCount(entryCount),
    .retainedCount(retainedCount), .allDeleted(allDeleted),
    .motorStartTrigger(motorStartTrigger), .motorRun(motorRun),
    .speed2(speed2), .currentBelowTransit(currentBelowTransit),
    .remoteTemperatureUnit(remoteTemperatureUnit), .chan(chan),
    .startRdIdx(startRdIdx), .startRdSample(startRdSample),
    .storing(storing), .startCount(startCount), .startRdSum(startRdSum),
    .startRdTrace(startRdTrace));

  log_operator u_op (.clk(clk), .rdEntry(rdEntry),
    .allDeleted(allDeleted), .clearAll(clearAll), .rdIdx(rdIdx));

  // ==========================================================================
  // Expectations and tasks
  // ==========================================================================
  function automatic logic [15:0] expVals(rec_pkg::event_in_t ev);
    case (ev.kind)
      rec_pkg::KIND_BINARY: return {7'h00, ~ev.curVal[0], 7'h00, ev.curVal[0]};
      rec_pkg::KIND_COUNTER: return {ev.curVal - 8'h01, ev.curVal};
      default: return {ev.prevVal, ev.curVal};
    endcase
  endfunction

  task automatic send(input logic [1:0] k, input logic al);
    rec_pkg::event_in_t ev;
    rec_pkg::log_entry_t e;
    logic [31:0] ts;
    logic ar, ra;
    ev = rec_pkg::event_in_t'($random(seed));
    ev.kind = k;
    ts = $random(seed);
    ar = 1'($random(seed));
    ra = 1'($random(seed));
    @(posedge clk);
    evtValid <= 1'b1;
    evtIn <= ev;
    timeStamp <= ts;
    protAlarm <= al;
    autoReclosing <= ar;
    reclosingActive <= ra;
    @(posedge clk);
    evtValid <= 1'b0;
    seq = seq + 16'h0001;
    if (al && !prevAl) begin
      fault = fault + 16'h0001;
      if (!(ar && ra)) grid = grid + 16'h0001;
    end
    prevAl = al;
    u_op.readEntry(9'h000, e);
    `CHK("seqNo", seq, e.seqNo)
    `CHK("faultNo", fault, e.faultNo)
    `CHK("gridNo", grid, e.gridNo)
    `CHK("stamp", ts, e.stamp)
    `CHK("itemId", ev.itemId, e.itemId)
    `CHK("vals", expVals(ev), {e.oldVal, e.newVal})
  endtask

  task automatic fill(input int n);
    repeat (n) begin
      @(posedge clk);
      evtValid <= 1'b1;
      evtIn <= rec_pkg::event_in_t'($random(seed));
      protAlarm <= 1'b0;
    end
    @(posedge clk);
    evtValid <= 1'b0;
    seq = seq + 16'(n);
    prevAl = 1'b0;
  endtask

  task automatic start(input logic run, input int n);
    rec_pkg::analog_t a, b;
    logic sp, tu, tr;
    logic [31:0] ts;
    logic [15:0] ticks;
    int w;
    a = {$random(seed), $random(seed), $random(seed)};
    b = a;
    b.i3 = a.i3 >> 1;
    b.unbal = a.unbal >> 1;
    sp = 1'($random(seed));
    tu = 1'($random(seed));
    tr = 1'($random(seed));
    ts = $random(seed);
    ticks = 16'((n + 1) / SAMPLE_TICK);
    @(posedge clk);
    motorStartTrigger <= 1'b1;
    speed2 <= sp;
    remoteTemperatureUnit <= tu;
    currentBelowTransit <= tr;
    chan <= a;
    timeStamp <= ts;
    @(posedge clk);
    #1;
    `CHK("storing", 1'b1, storing)
    @(posedge clk);
    chan <= b;
    repeat (n - 1) @(posedge clk);
    if (run) motorRun <= 1'b1;
    else motorStartTrigger <= 1'b0;
    w = 0;
    while (storing !== 1'b0 && w < 50) begin
      @(posedge clk);
      #1;
      w++;
    end
    `CHK("storingEnd", 1'b0, storing)
    recNo = recNo + 16'h0001;
    nStarts++;
    @(posedge clk);
    motorRun <= 1'b0;
    motorStartTrigger <= 1'b0;
    currentBelowTransit <= 1'b0;
    startRdIdx <= 3'h0;
    startRdSample <= 3'h0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("startCount", 3'(nStarts > 5 ? 5 : nStarts), startCount)
    `CHK("recNo", recNo, startRdSum.recNo)
    `CHK("date", ts, startRdSum.stamp)
    `CHK("maxI3", a.i3, startRdSum.maxI3)
    `CHK("maxUnbal", a.unbal, startRdSum.maxUnbal)
    `CHK("thermal", b.thermal, startRdSum.thermal)
    `CHK("twoSpeed", sp, startRdSum.twoSpeed)
    `CHK("success", run, startRdSum.success)
    `CHK("incomplete", !run, startRdSum.incomplete)
    `CHK("runTime", ticks, startRdSum.runTime)
    `CHK("transit", tr ? 16'h0000 : ticks, startRdSum.transitTime)
    `CHK("traceI1", a.i1, startRdTrace.i1)
    `CHK("traceUnbal", a.unbal, startRdTrace.unbal)
    `CHK("traceTemp", tu ? a.temp : 16'h0000, startRdTrace.temp)
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rec_pkg::log_entry_t e;
    logic d;
    {resetn, evtValid, protAlarm, autoReclosing, reclosingActive} <= 5'h00;
    {motorStartTrigger, motorRun, speed2, currentBelowTransit} <= 4'h0;
    remoteTemperatureUnit <= 1'b0;
    timeStamp <= 32'h0000_0000;
    evtIn <= '0;
    chan <= '0;
    {startRdIdx, startRdSample} <= 6'h00;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("entryCount", 9'h000, entryCount)
    `CHK("startCount", 3'h0, startCount)
    for (int i = 0; i < 40; i++) send(2'(i % 4), 1'($random(seed)));
    $display("test events done");
    fill(310);
    u_op.readEntry(rec_pkg::LOG_DEPTH - 9'h001, e);
    `CHK("entryCount", rec_pkg::LOG_DEPTH, entryCount)
    `CHK("retained", rec_pkg::RETAIN_DEPTH, retainedCount)
    `CHK("oldestSeq", seq - 16'h012b, e.seqNo)
    `CHK("rdValid", 1'b1, rdValid)
    u_op.readEntry(rec_pkg::LOG_DEPTH, e);
    `CHK("rdValidOut", 1'b0, rdValid)
    $display("test full log done");
    u_op.clearLog(d);
    `CHK("allDeleted", 1'b1, d)
    `CHK("cleared", 9'h000, entryCount)
    send(rec_pkg::KIND_MULTI, 1'b1);
    `CHK("afterClear", 9'h001, entryCount)
    $display("test clear done");
    for (int i = 0; i < 7; i++) start(i % 3 != 1, 2 + ($random(seed) & 15));
    startRdIdx <= 3'h4;
    repeat (2) @(posedge clk);
    #1;
    `CHK("oldestRec", recNo - 16'h0004, startRdSum.recNo)
    $display("test starts done");
    report_and_stop;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end
endmodule // test_event_and_start_recorder
